/* hw/acc_alu_pkg.sv */
/*
  Shared constants and types for the accumulator adjust and decrement
  slice: opcode values, segment numbering, fault kinds and the packed
  carriers for requests, flags and memory operands.
  Assumes the decoder hands over one already-fetched opcode per request.
*/
package acc_alu_pkg;

  // Opcode values
  localparam logic [7:0] OPC_SIGN_WIDEN = 8'h99;
  localparam logic [7:0] OPC_BCD_ADD = 8'h27;
  localparam logic [7:0] OPC_BCD_SUB = 8'h2f;
  localparam logic [7:0] OPC_DEC_RM8 = 8'hfe;
  localparam logic [7:0] OPC_DEC_RM = 8'hff;
  localparam logic [4:0] OPC_DEC_SHORT_BASE = 5'h09;
  localparam logic [2:0] DEC_MODRM_REG = 3'h1;
  // Second byte after the 0x0f escape; value is arbitrary
  localparam logic [7:0] OPC_IDENT_DEFAULT = 8'ha2;

  // BCD correction constants
  localparam logic [3:0] BCD_DIGIT_MAX = 4'h9;
  localparam logic [7:0] BCD_LOW_FIX = 8'h06;
  localparam logic [7:0] BCD_HIGH_FIX = 8'h60;
  localparam logic [7:0] BCD_HIGH_MASK = 8'hf0;
  localparam logic [7:0] BCD_ADD_HIGH_MAX = 8'h90;
  localparam logic [7:0] BCD_SUB_HIGH_MAX = 8'h9f;

  // Segment register numbering
  localparam logic [2:0] SEG_ES = 3'h0;
  localparam logic [2:0] SEG_CS = 3'h1;
  localparam logic [2:0] SEG_SS = 3'h2;
  localparam logic [2:0] SEG_DS = 3'h3;
  localparam logic [2:0] SEG_FS = 3'h4;
  localparam logic [2:0] SEG_GS = 3'h5;
  localparam int SEG_COUNT = 6;

  // Privilege level at which misalignment is checked
  localparam logic [1:0] USER_CPL = 2'h3;
  // Reset value of the identification-support flag
  localparam logic IDENT_FLAG_RESET = 1'b0;

  // Operating mode
  typedef enum logic [1:0] {
    MODE_REAL = 2'b00,
    MODE_PROT = 2'b01,
    MODE_V86 = 2'b10
  } cpu_mode_t;

  // Fault kinds reported with a result
  typedef enum logic [2:0] {
    FAULT_NONE = 3'b000,
    FAULT_PROTECTION = 3'b001,
    FAULT_STACK = 3'b010,
    FAULT_PAGING = 3'b011,
    FAULT_MISALIGN = 3'b100
  } fault_kind_t;

  // Destination of a result write
  typedef enum logic [1:0] {
    WR_NONE = 2'b00,
    WR_ACC_HIGH = 2'b01,
    WR_ACC_LOW_BYTE = 2'b10,
    WR_DEST = 2'b11
  } wr_target_t;

  // Operation selected by the decoder
  typedef enum logic [2:0] {
    OP_NONE = 3'b000,
    OP_SIGN_WIDEN = 3'b001,
    OP_BCD_ADD = 3'b010,
    OP_BCD_SUB = 3'b011,
    OP_DEC = 3'b100,
    OP_IDENT = 3'b101
  } op_kind_t;

  // Arithmetic flags
  typedef struct packed {
    logic overflow_flag;
    logic sign_flag;
    logic zero_flag;
    logic aux_carry_flag;
    logic parity_flag;
    logic carry_flag;
  } arith_flags_t;

  // One request from the decoder
  typedef struct packed {
    logic [7:0] opcode;
    logic escape_0f;
    logic [2:0] modrm_reg;
    logic [2:0] modrm_rm;
    logic op_size_32;
    logic is_mem;
  } alu_req_t;

  // Memory operand description
  typedef struct packed {
    logic [31:0] eff_addr;
    logic [2:0] seg;
    logic seg_writable;
    logic page_violation;
    logic [31:0] page_code;
  } mem_ref_t;

endpackage

/* hw/acc_alu.sv */
/*
  Accumulator sign widening, packed BCD fixes after add and subtract,
  decrement by one with its memory faults, and the identification
  support flag.
  Assumes the decoder presents one request per valid pulse together with
  operand values, segment state and paging result for that same cycle;
  the register file and flag register apply the registered results.
*/
`timescale 1ns/1ps

// Functional notes
// RL1: 16-bit widen copies bit 15 everywhere
// RL2: 32-bit widen copies bit 31 everywhere
// RL3: One opcode serves both widen forms
// RL4: Operand size picks word or doubleword widen
// RL5: Add fix touches only accumulator low byte
// RL6: Add fix low digit: add 6, set aux
// RL7: Add fix high digit: add 60H, set carry
// RL8: BCD fixes set sign, zero, parity flags
// RL9: Sub fix uses accumulator low byte only
// RL10: Sub fix low digit: subtract 6, set aux
// RL11: Sub fix high digit: subtract 60H, carry
// RL12: Decrement subtracts one, carry untouched
// RL13: Decrement sets overflow, sign, zero, aux, parity
// RL14: Decrement has byte, full and short encodings
// RL15: Protected write to nonwritable segment faults
// RL16: Limit overrun on code/data segment faults
// RL17: Protected null data selector access faults
// RL18: Stack segment limit overrun gives stack fault
// RL19: Unaligned user access faults when checking enabled
// RL20: Paging violation gives paging fault with code
// RL21: Writable identification support flag
// RL22: Widen and identify keep flags, never fault
module acc_alu
  import acc_alu_pkg::*;
#(
  parameter logic [7:0] OPC_IDENT = OPC_IDENT_DEFAULT
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Request from the decoder
  input wire logic req_valid,
  input wire alu_req_t req,
  // Operands and current flags
  input wire logic [31:0] acc_32,
  input wire logic [31:0] dest_value,
  input wire arith_flags_t flags_in,
  // Machine state for fault checks
  input wire cpu_mode_t cpu_mode,
  input wire logic [1:0] cpl,
  input wire logic align_check_en,
  input wire mem_ref_t mem_ref,
  input wire logic [SEG_COUNT-1:0][31:0] seg_limit,
  input wire logic [SEG_COUNT-1:0] seg_null,
  // Software access to the identification support flag
  input wire logic ident_wr_en,
  input wire logic ident_wr_val,
  // Registered results
  output logic done,
  output logic unknown_op,
  output wr_target_t wr_target,
  output logic [2:0] wr_reg,
  output logic wr_byte,
  output logic wr_size_32,
  output logic [31:0] wr_data,
  output logic flags_wr,
  output arith_flags_t flags_out,
  output fault_kind_t fault_kind,
  output logic [31:0] fault_code,
  output logic ident_support_flag
);

  // Even parity of a byte: one when the count of ones is even
  function automatic logic even_parity(input logic [7:0] b);
    even_parity = ~^b;
  endfunction

  // Last byte of an access lies beyond the segment limit
  function automatic logic over_limit(input logic [31:0] ea,
                                      input logic [2:0] span,
                                      input logic [31:0] limit);
    logic [32:0] last;
    last = {1'b0, ea} + {30'h0, span};
    over_limit = last > {1'b0, limit};
  endfunction

  // ---------------------------------------------------------------
  // Opcode decode
  // ---------------------------------------------------------------

  // Plain one-byte opcodes are only seen without the escape
  wire logic plain_op = ~req.escape_0f;
  // RL3 single widen opcode
  wire logic is_widen = plain_op && (req.opcode == OPC_SIGN_WIDEN);
  // RL5 add fix opcode
  wire logic is_bcd_add = plain_op && (req.opcode == OPC_BCD_ADD);
  // RL9 sub fix opcode
  wire logic is_bcd_sub = plain_op && (req.opcode == OPC_BCD_SUB);
  // RL14 byte form of the decrement
  wire logic is_dec_rm8 = plain_op && (req.opcode == OPC_DEC_RM8) &&
                          (req.modrm_reg == DEC_MODRM_REG);
  // RL14 full width form of the decrement
  wire logic is_dec_rm = plain_op && (req.opcode == OPC_DEC_RM) &&
                         (req.modrm_reg == DEC_MODRM_REG);
  // RL14 short form with the register in the low bits
  wire logic is_dec_short = plain_op &&
                            (req.opcode[7:3] == OPC_DEC_SHORT_BASE);
  // Escape-prefixed identification request
  wire logic is_ident = req.escape_0f && (req.opcode == OPC_IDENT);
  // Any decrement form
  wire logic is_dec = is_dec_rm8 | is_dec_rm | is_dec_short;

  // Operation selected for this request
  wire op_kind_t op_kind = is_widen ? OP_SIGN_WIDEN :
                           is_bcd_add ? OP_BCD_ADD :
                           is_bcd_sub ? OP_BCD_SUB :
                           is_dec ? OP_DEC :
                           is_ident ? OP_IDENT : OP_NONE;

  // ---------------------------------------------------------------
  // Sign widening
  // ---------------------------------------------------------------

  // RL1 replicate bit 15 into the high word
  wire logic [31:0] widen_16 = {16'h0, {16{acc_32[15]}}};
  // RL2 replicate bit 31 into the high doubleword
  wire logic [31:0] widen_32 = {32{acc_32[31]}};
  // RL4 operand size picks the form
  wire logic [31:0] widen_val = req.op_size_32 ? widen_32 : widen_16;

  // ---------------------------------------------------------------
  // Packed BCD fix, shared first and second steps
  // ---------------------------------------------------------------

  // Low accumulator byte is the only operand
  wire logic [7:0] acc_low_byte = acc_32[7:0];
  // Low digit needs fixing
  wire logic low_fix = (acc_low_byte[3:0] > BCD_DIGIT_MAX) ||
                       flags_in.aux_carry_flag;
  // RL6 low digit add with carry out
  wire logic [8:0] add_low = {1'b0, acc_low_byte} + {1'b0, BCD_LOW_FIX};
  // RL10 low digit subtract with borrow out
  wire logic [8:0] sub_low = {1'b0, acc_low_byte} - {1'b0, BCD_LOW_FIX};

  // RL6 first add step result and carry
  wire logic [7:0] add_s1 = low_fix ? add_low[7:0] : acc_low_byte;
  wire logic add_cf1 = flags_in.carry_flag | (low_fix & add_low[8]);
  // RL10 first sub step result and carry
  wire logic [7:0] sub_s1 = low_fix ? sub_low[7:0] : acc_low_byte;
  wire logic sub_cf1 = flags_in.carry_flag | (low_fix & sub_low[8]);

  // RL7 high digit test on the masked byte
  wire logic add_high_fix = ((add_s1 & BCD_HIGH_MASK) > BCD_ADD_HIGH_MAX) ||
                            add_cf1;
  // RL11 high digit test on the whole byte
  wire logic sub_high_fix = (sub_s1 > BCD_SUB_HIGH_MAX) || sub_cf1;

  // RL7 second add step
  wire logic [7:0] add_s2 = add_high_fix ? add_s1 + BCD_HIGH_FIX : add_s1;
  // RL11 second sub step
  wire logic [7:0] sub_s2 = sub_high_fix ? sub_s1 - BCD_HIGH_FIX : sub_s1;

  // Adjusted byte and flags of whichever fix is running
  wire logic [7:0] bcd_byte = is_bcd_sub ? sub_s2 : add_s2;
  wire logic bcd_cf = is_bcd_sub ? sub_high_fix : add_high_fix;

  // RL8 result flags; overflow keeps its old value
  wire arith_flags_t bcd_flags = '{
    overflow_flag: flags_in.overflow_flag,
    sign_flag: bcd_byte[7],
    zero_flag: bcd_byte == 8'h00,
    aux_carry_flag: low_fix,
    parity_flag: even_parity(bcd_byte),
    carry_flag: bcd_cf
  };

  // ---------------------------------------------------------------
  // Decrement
  // ---------------------------------------------------------------

  // Byte form works on eight bits; the others follow operand size
  wire logic dec_byte = is_dec_rm8;
  wire logic dec_32 = ~dec_byte & req.op_size_32;
  // RL12 subtract one
  wire logic [31:0] dec_full = dest_value - 32'h1;
  // Result clipped to the operand width
  wire logic [31:0] dec_val = dec_byte ? {24'h0, dec_full[7:0]} :
                              dec_32 ? dec_full :
                              {16'h0, dec_full[15:0]};
  // Sign bit of the operand and of the result
  wire logic dec_src_sign = dec_byte ? dest_value[7] :
                            dec_32 ? dest_value[31] : dest_value[15];
  wire logic dec_res_sign = dec_byte ? dec_val[7] :
                            dec_32 ? dec_val[31] : dec_val[15];

  // RL13 flags from the result; RL12 carry kept
  wire arith_flags_t dec_flags = '{
    overflow_flag: dec_src_sign & ~dec_res_sign,
    sign_flag: dec_res_sign,
    zero_flag: dec_val == 32'h0,
    aux_carry_flag: dest_value[3:0] == 4'h0,
    parity_flag: even_parity(dec_val[7:0]),
    carry_flag: flags_in.carry_flag
  };

  // Destination register: short form carries it in the opcode
  wire logic [2:0] dec_reg = is_dec_short ? req.opcode[2:0] : req.modrm_rm;

  // ---------------------------------------------------------------
  // Memory operand faults of the decrement
  // ---------------------------------------------------------------

  // A memory access only exists for the modrm forms
  wire logic mem_access = (is_dec_rm8 | is_dec_rm) & req.is_mem;
  wire logic prot_mode = cpu_mode == MODE_PROT;
  wire logic real_mode = cpu_mode == MODE_REAL;
  // Bytes beyond the first one touched by the access
  wire logic [2:0] span = dec_byte ? 3'h0 : dec_32 ? 3'h3 : 3'h1;
  // Selected segment and its limit check
  wire logic [2:0] seg = mem_ref.seg;
  wire logic seg_ok = seg < SEG_COUNT;
  wire logic [31:0] cur_limit = seg_ok ? seg_limit[seg] : 32'h0;
  wire logic beyond = over_limit(mem_ref.eff_addr, span, cur_limit);
  wire logic is_stack_seg = seg == SEG_SS;
  // Data segments that may hold a null selector
  wire logic is_data_seg = (seg == SEG_DS) || (seg == SEG_ES) ||
                           (seg == SEG_FS) || (seg == SEG_GS);
  wire logic cur_null = seg_ok ? seg_null[seg] : 1'b0;

  // RL15 write into a nonwritable segment
  wire logic gp_nonwritable = prot_mode & ~mem_ref.seg_writable;
  // RL16 code or data segment limit overrun
  wire logic gp_limit = ~is_stack_seg & beyond;
  // RL17 null data selector in protected mode
  wire logic gp_null = prot_mode & is_data_seg & cur_null;
  // RL18 stack segment limit overrun
  wire logic ss_limit = is_stack_seg & beyond;
  // RL20 paging violation outside real mode
  wire logic pf_hit = ~real_mode & mem_ref.page_violation;
  // RL19 misaligned reference while checking is on
  wire logic misaligned = dec_32 ? (mem_ref.eff_addr[1:0] != 2'h0) :
                          dec_byte ? 1'b0 : mem_ref.eff_addr[0];
  wire logic ac_hit = align_check_en & misaligned &
                      ((prot_mode & (cpl == USER_CPL)) |
                       (cpu_mode == MODE_V86));

  // Fault priority: protection, stack, paging, alignment
  wire fault_kind_t mem_fault =
    ~mem_access ? FAULT_NONE :
    (gp_nonwritable | gp_limit | gp_null) ? FAULT_PROTECTION :
    ss_limit ? FAULT_STACK :
    pf_hit ? FAULT_PAGING :
    ac_hit ? FAULT_MISALIGN : FAULT_NONE;
  // RL20 paging faults carry their code; others report zero
  wire logic [31:0] mem_fault_code = (mem_fault == FAULT_PAGING) ?
                                     mem_ref.page_code : 32'h0;
  wire logic faulted = mem_fault != FAULT_NONE;

  // ---------------------------------------------------------------
  // Result selection
  // ---------------------------------------------------------------

  // Write target per operation; faults cancel the write
  wire wr_target_t target_sel =
    (op_kind == OP_SIGN_WIDEN) ? WR_ACC_HIGH :
    ((op_kind == OP_BCD_ADD) || (op_kind == OP_BCD_SUB)) ? WR_ACC_LOW_BYTE :
    ((op_kind == OP_DEC) && ~faulted) ? WR_DEST : WR_NONE;

  // Data to write
  wire logic [31:0] data_sel =
    (op_kind == OP_SIGN_WIDEN) ? widen_val :
    ((op_kind == OP_BCD_ADD) || (op_kind == OP_BCD_SUB)) ?
      {24'h0, bcd_byte} :
    (op_kind == OP_DEC) ? dec_val : 32'h0;

  // RL22 flags only change for the fixes and a clean decrement
  wire logic flags_sel = (op_kind == OP_BCD_ADD) ||
                         (op_kind == OP_BCD_SUB) ||
                         ((op_kind == OP_DEC) && ~faulted);
  wire arith_flags_t flags_val = ~flags_sel ? flags_in :
                                 (op_kind == OP_DEC) ? dec_flags : bcd_flags;

  // Register index and width that go with the write
  wire logic [2:0] reg_sel = (op_kind == OP_DEC) ? dec_reg : 3'h0;
  wire logic byte_sel = (op_kind == OP_DEC) ? dec_byte :
                        (op_kind != OP_SIGN_WIDEN);
  wire logic size_sel = (op_kind == OP_DEC) ? dec_32 : req.op_size_32;

  // ---------------------------------------------------------------
  // Registered outputs
  // ---------------------------------------------------------------

  // Result pulse and its payload, one cycle after the request
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      done <= 1'b0;
      unknown_op <= 1'b0;
      wr_target <= WR_NONE;
      flags_wr <= 1'b0;
      fault_kind <= FAULT_NONE;
    end else begin
      done <= req_valid;
      unknown_op <= req_valid && (op_kind == OP_NONE);
      wr_target <= req_valid ? target_sel : WR_NONE;
      flags_wr <= req_valid && flags_sel;
      // RL22 widen and identify never raise a fault
      fault_kind <= req_valid ? mem_fault : FAULT_NONE;
    end
  end

  // Payload registers hold their value between requests
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      wr_reg <= 3'h0;
      wr_byte <= 1'b0;
      wr_size_32 <= 1'b0;
      wr_data <= 32'h0;
      flags_out <= '0;
      fault_code <= 32'h0;
    end else if (req_valid) begin
      wr_reg <= reg_sel;
      wr_byte <= byte_sel;
      wr_size_32 <= size_sel;
      wr_data <= data_sel;
      flags_out <= flags_val;
      fault_code <= mem_fault_code;
    end
  end

  // RL21 identification support flag, freely writable
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ident_support_flag <= IDENT_FLAG_RESET;
    end else if (ident_wr_en) begin
      ident_support_flag <= ident_wr_val;
    end
  end

endmodule // acc_alu

/* verif/flag_file_model.sv */
/*
  Far side model: the flag register and the high accumulator half that
  take the slice's registered results.
  Assumes one clock and a synchronous reset; preload comes from the bench.
*/
`timescale 1ns/1ps
module flag_file_model
  import acc_alu_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Preload from the bench
  input wire logic ld_en,
  input wire arith_flags_t ld_val,
  // Results from the slice
  input wire logic flags_wr,
  input wire arith_flags_t flags_out,
  input wire wr_target_t wr_target,
  input wire logic [31:0] wr_data,
  // State handed back
  output arith_flags_t flags_reg,
  output logic [31:0] acc_high_reg
);
  // Flags follow a preload or a flag write; high half follows widening
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      flags_reg <= '0;
      acc_high_reg <= 32'h0;
    end else begin
      if (ld_en) begin
        flags_reg <= ld_val;
      end else if (flags_wr) begin
        flags_reg <= flags_out;
      end
      if (wr_target == WR_ACC_HIGH) begin
        acc_high_reg <= wr_data;
      end
    end
  end
endmodule // flag_file_model

/* verif/acc_alu_assertions.sv */
/*
  Port checker for the adjust and decrement slice.
  Assumes one clock domain and results one cycle after each request.
*/
`timescale 1ns/1ps
module acc_alu_checker
  import acc_alu_pkg::*;
(
  // Clock, reset and request side
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic req_valid,
  input wire alu_req_t req,
  input wire logic [31:0] acc_32,
  input wire logic [31:0] dest_value,
  input wire arith_flags_t flags_in,
  input wire logic ident_wr_en,
  input wire logic ident_wr_val,
  // Result side
  input wire wr_target_t wr_target,
  input wire logic wr_byte,
  input wire logic [31:0] wr_data,
  input wire logic flags_wr,
  input wire arith_flags_t flags_out,
  input wire fault_kind_t fault_kind,
  input wire logic ident_support_flag
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  // Request decodes
  wire logic widen_op = req_valid && req.opcode == OPC_SIGN_WIDEN &&
    !req.escape_0f;
  wire logic bcd_op = req_valid && !req.escape_0f &&
    (req.opcode == OPC_BCD_ADD || req.opcode == OPC_BCD_SUB);
  wire logic short_dec = req_valid && !req.escape_0f &&
    req.opcode[7:3] == OPC_DEC_SHORT_BASE && req.op_size_32;

  widen16_a: assert property (widen_op && !req.op_size_32 |=>
    wr_target == WR_ACC_HIGH && wr_data == {16'h0, {16{$past(acc_32[15])}}})
    else $error("word widen result wrong");
  widen32_a: assert property (widen_op && req.op_size_32 |=>
    wr_target == WR_ACC_HIGH && wr_data == {32{$past(acc_32[31])}})
    else $error("dword widen result wrong");
  widen_quiet_a: assert property (widen_op |=> !flags_wr &&
    fault_kind == FAULT_NONE) else $error("widen touched flags");
  bcd_byte_a: assert property (bcd_op |=> wr_byte &&
    wr_target == WR_ACC_LOW_BYTE && wr_data[31:8] == 24'h0)
    else $error("bcd fix wrote beyond low byte");
  bcd_flags_a: assert property (bcd_op |=> flags_wr &&
    flags_out.zero_flag == (wr_data[7:0] == 8'h0) &&
    flags_out.sign_flag == wr_data[7] &&
    flags_out.parity_flag == ~^wr_data[7:0])
    else $error("bcd fix result flags wrong");
  bcd_carry_a: assert property (bcd_op &&
    req.opcode == OPC_BCD_ADD && acc_32[7:0] > 8'h99
    |=> flags_out.carry_flag) else $error("bcd add carry lost");
  dec_value_a: assert property (short_dec |=>
    wr_data == $past(dest_value) - 32'h1 &&
    flags_out.carry_flag == $past(flags_in.carry_flag))
    else $error("decrement value or carry wrong");
  dec_zero_a: assert property (short_dec && dest_value == 32'h1
    |=> flags_wr && flags_out.zero_flag && !flags_out.sign_flag)
    else $error("decrement to zero flags wrong");
  ident_flag_a: assert property (ident_wr_en
    |=> ident_support_flag == $past(ident_wr_val))
    else $error("ident flag write lost");

  widen_c: cover property (widen_op ##1 wr_target == WR_ACC_HIGH);
  bcd_c: cover property (bcd_op ##1 flags_out.carry_flag);
  dec_c: cover property (short_dec && dest_value == 32'h1);
endmodule // acc_alu_checker

bind acc_alu acc_alu_checker chk_u (.clk_sys, .rst, .req_valid, .req,
  .acc_32, .dest_value, .flags_in, .ident_wr_en, .ident_wr_val,
  .wr_target, .wr_byte, .wr_data, .flags_wr, .flags_out, .fault_kind,
  .ident_support_flag);

/* verif/acc_alu_tb.sv */
/*
  Self-checking bench for the adjust and decrement slice.
  Assumes the flag file model on the far side; inputs move at negedge.
*/
`timescale 1ns/1ps
module acc_alu_tb
  import acc_alu_pkg::*;
;
  logic clk_sys, rst, req_valid, ident_wr_en, ident_wr_val, ld_en;
  alu_req_t req;
  logic [31:0] acc_32, dest_value, wr_data, fault_code, acc_high_reg;
  arith_flags_t flags_in, flags_out, ld_val;
  cpu_mode_t cpu_mode;
  logic [1:0] cpl;
  logic align_check_en, done, unknown_op, wr_byte, wr_size_32;
  logic flags_wr, ident_support_flag;
  mem_ref_t mem_ref;
  logic [SEG_COUNT-1:0][31:0] seg_limit;
  logic [SEG_COUNT-1:0] seg_null;
  wr_target_t wr_target;
  logic [2:0] wr_reg;
  fault_kind_t fault_kind;
  int mismatches = 0;
  int tests_run = 0;

  acc_alu dut_u (.clk_sys, .rst, .req_valid, .req, .acc_32, .dest_value,
    .flags_in, .cpu_mode, .cpl, .align_check_en, .mem_ref, .seg_limit,
    .seg_null, .ident_wr_en, .ident_wr_val, .done, .unknown_op,
    .wr_target, .wr_reg, .wr_byte, .wr_size_32, .wr_data, .flags_wr,
    .flags_out, .fault_kind, .fault_code, .ident_support_flag);
  flag_file_model far_u (.clk_sys, .rst, .ld_en, .ld_val, .flags_wr,
    .flags_out, .wr_target, .wr_data, .flags_reg(flags_in),
    .acc_high_reg);

  always #5 clk_sys = ~clk_sys;

  task automatic conclude();
    $display("mismatches=%0d tests_run=%0d", mismatches, tests_run);
    if (mismatches == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Preload flags, issue one request, return in the done cycle
  task automatic send(input logic [7:0] opc, input logic esc,
    input logic [2:0] mreg, input logic sz, input logic mem,
    input logic [31:0] a, input logic [31:0] d, input arith_flags_t f);
    int i;
    ld_en = 1'b1;
    ld_val = f;
    @(negedge clk_sys);
    ld_en = 1'b0;
    req = '{opcode: opc, escape_0f: esc, modrm_reg: mreg,
      modrm_rm: 3'h5, op_size_32: sz, is_mem: mem};
    acc_32 = a;
    dest_value = d;
    req_valid = 1'b1;
    @(negedge clk_sys);
    req_valid = 1'b0;
    for (i = 0; i < 4 && done !== 1'b1; i++) @(negedge clk_sys);
    if (done !== 1'b1) begin
      mismatches++;
      conclude();
    end
  endtask

  task automatic widen_one(input logic sz, input logic [31:0] a,
    input logic [31:0] e);
    send(OPC_SIGN_WIDEN, 1'b0, 3'h0, sz, 1'b0, a, 32'h0, 6'h3f);
    chk(wr_data, e);
    chk({wr_target, flags_wr, fault_kind}, {WR_ACC_HIGH, 1'b0, 3'h0});
    @(negedge clk_sys);
    chk({acc_high_reg, flags_in}, {e, 6'h3f});
  endtask

  // Widen both sizes and signs while a paging violation is presented
  task automatic t_widen();
    mem_ref.page_violation = 1'b1;
    widen_one(1'b0, 32'h0000_8000, 32'h0000_ffff);
    widen_one(1'b0, 32'hffff_7fff, 32'h0);
    widen_one(1'b1, 32'h8000_0000, 32'hffff_ffff);
    widen_one(1'b1, 32'h7fff_ffff, 32'h0);
    mem_ref.page_violation = 1'b0;
  endtask

  function automatic logic [9:0] bcd_ref(input logic sb,
    input logic [7:0] v, input logic c, input logic a);
    logic [8:0] t;
    if (v[3:0] > 4'h9 || a) begin
      t = sb ? {1'b0, v} - 9'h6 : {1'b0, v} + 9'h6;
      c = c | t[8];
      a = 1'b1;
      v = t[7:0];
    end else a = 1'b0;
    if ((sb ? v > 8'h9f : (v & 8'hf0) > 8'h90) || c) begin
      v = sb ? v - 8'h60 : v + 8'h60;
      c = 1'b1;
    end else c = 1'b0;
    return {c, a, v};
  endfunction

  task automatic bcd_one(input logic sb, input logic [7:0] v,
    input logic c, input logic a);
    logic [9:0] e;
    e = bcd_ref(sb, v, c, a);
    send(sb ? OPC_BCD_SUB : OPC_BCD_ADD, 1'b0, 3'h0, 1'b0, 1'b0,
      {24'h123456, v}, 32'h0, {3'h0, a, 1'b0, c});
    chk({wr_target, wr_byte, wr_data}, {WR_ACC_LOW_BYTE, 1'b1, 24'h0,
      e[7:0]});
    chk({flags_out.carry_flag, flags_out.aux_carry_flag},
      e[9:8]);
    chk({flags_out.sign_flag, flags_out.zero_flag, flags_out.parity_flag},
      {e[7], e[7:0] == 8'h0, ~^e[7:0]});
  endtask

  // Both fixes across digit boundaries and incoming carries
  task automatic t_bcd();
    bcd_one(1'b0, 8'hae, 1'b0, 1'b0);
    bcd_one(1'b0, 8'h9a, 1'b0, 1'b0);
    bcd_one(1'b0, 8'h00, 1'b0, 1'b0);
    bcd_one(1'b0, 8'h12, 1'b1, 1'b1);
    bcd_one(1'b1, 8'hee, 1'b1, 1'b1);
    bcd_one(1'b1, 8'h00, 1'b0, 1'b0);
    bcd_one(1'b1, 8'h03, 1'b0, 1'b1);
  endtask

  task automatic dec_one(input logic [7:0] opc, input logic sz,
    input logic [31:0] d, input logic c, input logic [31:0] ed,
    input logic [4:0] ef, input logic [2:0] er);
    send(opc, 1'b0, DEC_MODRM_REG, sz, 1'b0, 32'h0, d, {5'h0, c});
    chk(wr_data, ed);
    chk({flags_wr, flags_out}, {1'b1, ef, c});
    chk({wr_target, wr_reg, wr_size_32}, {WR_DEST, er, sz});
  endtask

  // Every short form plus both modrm forms, carry in both states
  task automatic t_dec();
    int r;
    for (r = 0; r < 8; r++) begin
      dec_one({OPC_DEC_SHORT_BASE, r[2:0]}, 1'b0, 32'h1234_8000, r[0],
        32'h7fff, 5'h13, r[2:0]);
    end
    dec_one({OPC_DEC_SHORT_BASE, 3'h3}, 1'b1, 32'h1, 1'b1, 32'h0, 5'h05, 3'h3);
    dec_one(OPC_DEC_RM8, 1'b0, 32'h0, 1'b1, 32'hff, 5'h0b, 3'h5);
    dec_one(OPC_DEC_RM, 1'b1, 32'h1, 1'b0, 32'h0, 5'h05, 3'h5);
    chk(wr_byte, 1'b0);
  endtask

  // One memory decrement per fault cause, plus two clean cases
  task automatic t_fault();
    int k;
    fault_kind_t ek[8] = '{FAULT_PROTECTION, FAULT_PROTECTION,
      FAULT_PROTECTION, FAULT_STACK, FAULT_PAGING, FAULT_MISALIGN,
      FAULT_NONE, FAULT_NONE};
    seg_limit = {SEG_COUNT{32'h100}};
    for (k = 0; k < 8; k++) begin
      mem_ref = '{eff_addr: 32'h10, seg: SEG_DS, seg_writable: 1'b1,
        page_violation: 1'b0, page_code: 32'h5a};
      seg_null = '0;
      cpu_mode = MODE_PROT;
      cpl = 2'h0;
      align_check_en = 1'b1;
      case (k)
        0: mem_ref.seg_writable = 1'b0;
        1: mem_ref.eff_addr = 32'hfff;
        2: seg_null[SEG_DS] = 1'b1;
        3: begin
          mem_ref.seg = SEG_SS;
          mem_ref.eff_addr = 32'hfff;
        end
        4: mem_ref.page_violation = 1'b1;
        5: begin
          cpl = USER_CPL;
          mem_ref.eff_addr = 32'h11;
        end
        6: mem_ref.eff_addr = 32'h11;
        default: begin
          cpu_mode = MODE_REAL;
          mem_ref.seg_writable = 1'b0;
        end
      endcase
      send(OPC_DEC_RM, 1'b0, DEC_MODRM_REG, 1'b1, 1'b1, 32'h0, 32'h5,
        '0);
      chk(fault_kind, ek[k]);
      chk(fault_code, k == 4 ? 32'h5a : 32'h0);
      chk({wr_target, flags_wr}, k > 5 ? {WR_DEST, 1'b1} : 3'h0);
    end
    seg_limit = '1;
  endtask

  // Flag writes both ways, the identify op and an undecoded opcode
  task automatic t_ident();
    int b;
    ident_wr_en = 1'b1;
    for (b = 1; b >= 0; b--) begin
      ident_wr_val = b[0];
      @(negedge clk_sys);
      chk(ident_support_flag, b[0]);
    end
    ident_wr_en = 1'b0;
    send(OPC_IDENT_DEFAULT, 1'b1, 3'h0, 1'b1, 1'b1, 32'h0, 32'h0, 6'h3f);
    chk({wr_target, flags_wr, fault_kind, unknown_op}, 6'h0);
    send(8'h00, 1'b0, 3'h0, 1'b0, 1'b0, 32'h0, 32'h0, '0);
    chk({unknown_op, flags_wr}, 2'h2);
  endtask

  initial begin
    clk_sys = 1'b0;
    rst = 1'b1;
    {req_valid, ident_wr_en, ident_wr_val, ld_en, align_check_en} = '0;
    {req, acc_32, dest_value, ld_val, cpl, seg_null} = '0;
    mem_ref = '0;
    cpu_mode = MODE_PROT;
    seg_limit = '1;
    repeat (3) @(negedge clk_sys);
    rst = 1'b0;
    chk(ident_support_flag, IDENT_FLAG_RESET);
    t_widen();
    t_bcd();
    t_dec();
    t_fault();
    t_ident();
    conclude();
  end
endmodule // acc_alu_tb
